// ### logic/ttnr_pkg.sv
// Shared constants and carrier types for the token timeout and node records.
// Assumes a single 100 MHz clock domain.
`default_nettype none
package ttnr_pkg;
  localparam int NPORT = 2;
  localparam int PW = 1;
  localparam int NREC = 16;
  localparam int IDXW = 4;
  localparam int PRIO_W = 3;
  localparam int CLK_MHZ = 100;
  localparam int TOK_PERIOD_MS = 100;
  localparam int TOK_CYC = TOK_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int TCW = 24;
  localparam logic [15:0] ID_RSVD = 16'h0000;
  localparam logic [PRIO_W-1:0] PRIO_NONE = 3'h0;
  localparam logic [1:0] NPORTS_SINGLE = 2'h1;

  typedef struct packed {
    logic valid;
    logic [63:0] ident;
    logic [PRIO_W-1:0] prio;
    logic [1:0] nports;
    logic [31:0] path;
    logic [PW-1:0] lport;
  } ttnr_cfg_rec_t;

  typedef struct packed {
    logic [15:0] alert_tag;
    logic [31:0] alert_reply_path;
    logic [7:0] alert_reply_port;
    logic [IDXW-1:0] alert_node_ref;
  } ttnr_alert_rec_t;

  typedef struct packed {
    logic valid;
    logic [IDXW-1:0] idx;
    ttnr_cfg_rec_t rec;
  } ttnr_cfg_wr_t;

  typedef struct packed {
    logic valid;
    ttnr_alert_rec_t rec;
  } ttnr_alert_wr_t;

  typedef struct packed {
    logic valid;
    logic [PW-1:0] port;
    logic reset_ctrl;
  } ttnr_tx_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] nports;
    logic oper;
    logic ident_known;
  } ttnr_walk_step_t;

  typedef struct packed {
    logic valid;
    logic [IDXW-1:0] idx;
    logic [PW-1:0] port;
  } ttnr_setup_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WALK = 3'h2,
    ST_SWEEP = 3'h4
  } ttnr_state_t;
endpackage : ttnr_pkg
`default_nettype wire

// ### logic/ttnr_rec_mem.sv
// Small record memory, one write port and a registered read port.
// Assumes the caller holds the read address one cycle for its data.
`default_nettype none
module ttnr_rec_mem #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clk, // Clock
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [W-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [W-1:0] rdata // Registered read data
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : ttnr_rec_mem
`default_nettype wire

// ### logic/ttnr_core.sv
// Lost-token watchdogs per port, node identity, configuration and
// alert-address records, pending flags, link walk and setup sweep.
// Assumes one clock; sys_rst release marks power-on completion.
// Functional notes
// - Each port has a 100 ms lost-token watchdog.
// - Watchdog starts after power-on, total reset or absolute reset.
// - Forwarding or reflecting a token reloads the full period.
// - Expiry makes an internal token, handled as if received.
// - Identifier is eight bytes; bytes 0-1 zero, 2-7 universal address.
// - Bytes 2-4 hold organization code, bytes 5-7 product number.
// - Records hold 3-bit master priority; zero means never master.
// - Pending flag set while message awaits reply, cleared on reply.
// - Setup message writes alert record; alerts look it up.
// - Alert record: 2-byte tag, 4-byte path, 1-byte port, record ref.
// - Master sends setup message to every port, operational or not.
// - Configuration never walks through a non-operational port.
// - Walk new link until single-port node, dead port or known id.
// - Node that cannot be master never configures or builds a table.
// - Non-operational port sends only reset or reserved control frames.
`default_nettype none
module ttnr_core import ttnr_pkg::*; #(
  parameter int unsigned TOK_CYCLES = TOK_CYC,
  parameter logic [23:0] OUI = 24'h123456, // Arbitrary value
  parameter logic [23:0] PRODUCT = 24'h000001 // Arbitrary value
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic [NPORT-1:0] port_reset_done, // Total/absolute reset done
  input wire logic [NPORT-1:0] token_fwd, // Token forwarded or reflected
  input wire logic [NPORT-1:0] oper_flag, // Port operational flags
  input wire logic [PRIO_W-1:0] own_prio, // Own master priority
  input wire ttnr_cfg_wr_t cfg_wr, // Configuration record write
  input wire logic [IDXW-1:0] cfg_rd_idx, // Configuration record read
  input wire ttnr_alert_wr_t setup_sent, // Setup message sent
  input wire logic alert_rx, // Unsolicited alert received
  input wire logic [15:0] alert_rx_tag, // Its tag
  input wire logic msg_sent, // Management message sent
  input wire logic [IDXW-1:0] msg_sent_idx, // Its record
  input wire logic msg_reply, // Reply or related alert arrived
  input wire logic [IDXW-1:0] msg_reply_idx, // Its record
  input wire ttnr_tx_req_t tx_req, // Frame origination request
  input wire logic port_now_oper, // Port became operational
  input wire ttnr_walk_step_t walk_step, // Node found on walk
  input wire logic sweep_start, // Begin setup sweep
  output logic [NPORT-1:0] token_gen_r, // Internal token pulse
  output logic [63:0] node_ident_r, // Node identifier
  output ttnr_cfg_rec_t cfg_rd_r, // Configuration record
  output logic [NREC-1:0] pend_r, // Pending flags
  output logic alert_hit_r, // Lookup result valid
  output ttnr_alert_rec_t alert_rec_r, // Looked-up alert record
  output logic tx_grant_r, // Frame may go
  output logic tx_refuse_r, // Frame refused
  output logic walk_busy_r, // Link walk active
  output logic walk_done_r, // Link walk ended
  output ttnr_setup_req_t setup_req_r, // Setup message request
  output logic sweep_busy_r // Sweep active
);
  localparam logic [TCW-1:0] TLOAD = TCW'(TOK_CYCLES);
  localparam logic [IDXW-1:0] LAST_REC = IDXW'(NREC - 1);
  localparam logic [PW-1:0] LAST_PORT = PW'(NPORT - 1);

  logic can_master;
  assign can_master = (own_prio != PRIO_NONE);

  // Watchdogs
  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_tok
      logic [TCW-1:0] cnt_r, cnt_nxt;
      logic gen_nxt;
      always_comb
      begin
        cnt_nxt = cnt_r - TCW'(1);
        gen_nxt = 1'b0;
        if (port_reset_done[p] || token_fwd[p])
        begin
          cnt_nxt = TLOAD;
        end
        else if (cnt_r == TCW'(1))
        begin
          gen_nxt = 1'b1;
          cnt_nxt = TLOAD;
        end
      end
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          cnt_r <= TLOAD;
          token_gen_r[p] <= 1'b0;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          token_gen_r[p] <= gen_nxt;
        end
      end
    end
  endgenerate

  // Identifier
  always_ff @(posedge clk)
  begin
    node_ident_r <= {ID_RSVD, OUI, PRODUCT};
  end

  // Configuration records
  ttnr_cfg_rec_t cfg_mem_q;
  logic [IDXW-1:0] cfg_raddr;
  logic cfg_we;
  assign cfg_we = cfg_wr.valid && can_master;
  ttnr_rec_mem #(.W($bits(ttnr_cfg_rec_t)), .D(NREC), .AW(IDXW)) u_cfg (
    .clk(clk),
    .we(cfg_we),
    .waddr(cfg_wr.idx),
    .wdata(cfg_wr.rec),
    .raddr(cfg_raddr),
    .rdata(cfg_mem_q)
  );

  // Alert-address records, indexed by the low tag bits
  ttnr_alert_rec_t al_mem_q;
  ttnr_rec_mem #(.W($bits(ttnr_alert_rec_t)), .D(NREC), .AW(IDXW)) u_alert (
    .clk(clk),
    .we(setup_sent.valid && can_master),
    .waddr(setup_sent.rec.alert_tag[IDXW-1:0]),
    .wdata(setup_sent.rec),
    .raddr(alert_rx_tag[IDXW-1:0]),
    .rdata(al_mem_q)
  );

  logic al_p1_r, al_p1_nxt;
  logic [15:0] al_tag_r;
  logic hit_nxt;
  always_comb
  begin
    al_p1_nxt = alert_rx && can_master;
    hit_nxt = al_p1_r && (al_mem_q.alert_tag == al_tag_r);
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      al_p1_r <= 1'b0;
      al_tag_r <= 16'h0000;
      alert_hit_r <= 1'b0;
      alert_rec_r <= '0;
    end
    else
    begin
      al_p1_r <= al_p1_nxt;
      al_tag_r <= alert_rx_tag;
      alert_hit_r <= hit_nxt;
      alert_rec_r <= al_mem_q;
    end
  end

  // Pending flags; a set beats a simultaneous clear
  logic [NREC-1:0] pend_nxt;
  always_comb
  begin
    pend_nxt = pend_r;
    if (msg_reply)
    begin
      pend_nxt[msg_reply_idx] = 1'b0;
    end
    if (msg_sent && can_master)
    begin
      pend_nxt[msg_sent_idx] = 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pend_r <= '0;
    end
    else
    begin
      pend_r <= pend_nxt;
    end
  end

  // Origination gate
  logic grant_nxt, refuse_nxt;
  always_comb
  begin
    grant_nxt = 1'b0;
    refuse_nxt = 1'b0;
    if (tx_req.valid)
    begin
      if (oper_flag[tx_req.port] || tx_req.reset_ctrl)
      begin
        grant_nxt = 1'b1;
      end
      else
      begin
        refuse_nxt = 1'b1;
      end
    end
  end

  // Walk and sweep control
  ttnr_state_t st_r, st_nxt;
  logic [IDXW-1:0] rec_r, rec_nxt;
  logic [PW-1:0] prt_r, prt_nxt;
  logic ph_r, ph_nxt;
  logic wdone_nxt;
  ttnr_setup_req_t sreq_nxt;
  always_comb
  begin
    st_nxt = st_r;
    rec_nxt = rec_r;
    prt_nxt = prt_r;
    ph_nxt = ph_r;
    wdone_nxt = 1'b0;
    sreq_nxt = '0;
    cfg_raddr = cfg_rd_idx;
    case (st_r)
      ST_IDLE:
      begin
        if (can_master && port_now_oper)
        begin
          st_nxt = ST_WALK;
        end
        else if (can_master && sweep_start)
        begin
          st_nxt = ST_SWEEP;
          rec_nxt = '0;
          prt_nxt = '0;
          ph_nxt = 1'b0;
        end
      end
      ST_WALK:
      begin
        if (walk_step.valid && (walk_step.nports == NPORTS_SINGLE
            || !walk_step.oper || walk_step.ident_known))
        begin
          st_nxt = ST_IDLE;
          wdone_nxt = 1'b1;
        end
      end
      ST_SWEEP:
      begin
        cfg_raddr = rec_r;
        ph_nxt = 1'b1;
        if (ph_r)
        begin
          // Every port regardless of its operational state
          sreq_nxt.valid = cfg_mem_q.valid;
          sreq_nxt.idx = rec_r;
          sreq_nxt.port = prt_r;
          ph_nxt = 1'b0;
          if (prt_r == LAST_PORT)
          begin
            prt_nxt = '0;
            rec_nxt = rec_r + IDXW'(1);
            if (rec_r == LAST_REC)
            begin
              st_nxt = ST_IDLE;
            end
          end
          else
          begin
            prt_nxt = prt_r + PW'(1);
          end
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= ST_IDLE;
      rec_r <= '0;
      prt_r <= '0;
      ph_r <= 1'b0;
      walk_busy_r <= 1'b0;
      walk_done_r <= 1'b0;
      sweep_busy_r <= 1'b0;
      setup_req_r <= '0;
      tx_grant_r <= 1'b0;
      tx_refuse_r <= 1'b0;
      cfg_rd_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      rec_r <= rec_nxt;
      prt_r <= prt_nxt;
      ph_r <= ph_nxt;
      walk_busy_r <= (st_nxt == ST_WALK);
      walk_done_r <= wdone_nxt;
      sweep_busy_r <= (st_nxt == ST_SWEEP);
      setup_req_r <= sreq_nxt;
      tx_grant_r <= grant_nxt;
      tx_refuse_r <= refuse_nxt;
      cfg_rd_r <= cfg_mem_q;
    end
  end
endmodule : ttnr_core
`default_nettype wire

// ### tb/ttnr_core_properties.sv
// Concurrent checks on the ports of ttnr_core.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module ttnr_core_properties import ttnr_pkg::*; #(
  parameter int unsigned TOK_CYCLES = 20
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [NPORT-1:0] port_reset_done, // Reset done
  input wire logic [NPORT-1:0] token_fwd, // Token passed
  input wire logic [NPORT-1:0] token_gen_r, // Own token
  input wire logic [63:0] node_ident_r, // Identifier
  input wire logic [PRIO_W-1:0] own_prio, // Priority
  input wire logic msg_sent, // Sent
  input wire logic [IDXW-1:0] msg_sent_idx, // Sent index
  input wire logic [NREC-1:0] pend_r, // Pending
  input wire ttnr_tx_req_t tx_req, // Frame request
  input wire logic [NPORT-1:0] oper_flag, // Operational
  input wire logic tx_grant_r, // Grant
  input wire logic tx_refuse_r, // Refuse
  input wire logic port_now_oper, // Walk start
  input wire ttnr_walk_step_t walk_step, // Walk step
  input wire logic walk_busy_r, // Walking
  input wire logic walk_done_r, // Walk over
  input wire logic sweep_start, // Sweep start
  input wire logic sweep_busy_r // Sweeping
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  int unsigned since0;
  logic ok_r;
  // Cycles since port 0 last reloaded or expired
  always_ff @(posedge clk)
  begin
    since0 <= (sys_rst || token_fwd[0] || port_reset_done[0]) ? 0 :
      (token_gen_r[0] ? 1 : since0 + 1);
    ok_r <= oper_flag[tx_req.port] || tx_req.reset_ctrl;
  end
  sequence s_sweep_go;
    sweep_start && !sweep_busy_r && !walk_busy_r && !port_now_oper &&
      own_prio != PRIO_NONE;
  endsequence
  sequence s_sweep_run;
    sweep_busy_r [*8];
  endsequence
  sequence s_walk_stop;
    walk_busy_r && walk_step.valid && (walk_step.nports == NPORTS_SINGLE ||
      !walk_step.oper || walk_step.ident_known);
  endsequence
  chk_tok_period:
    assert property (token_gen_r[0] == (since0 == TOK_CYCLES))
    else $error("token pulse off period");
  chk_ident_rsvd:
    assert property (node_ident_r[63:48] == ID_RSVD)
    else $error("ident top bytes not zero");
  chk_pend_set:
    assert property (msg_sent && own_prio != PRIO_NONE
      |=> pend_r[$past(msg_sent_idx)])
    else $error("pending flag not set");
  chk_pend_refuse:
    assert property (msg_sent && own_prio == PRIO_NONE &&
      !pend_r[msg_sent_idx] |=> !pend_r[$past(msg_sent_idx)])
    else $error("pending set without master");
  chk_tx_gate:
    assert property (tx_req.valid
      |=> tx_grant_r == ok_r && tx_refuse_r == !ok_r)
    else $error("frame gate wrong");
  chk_sweep_run:
    assert property (s_sweep_go |=> s_sweep_run)
    else $error("sweep ended early");
  chk_no_master:
    assert property (own_prio == PRIO_NONE && !walk_busy_r && !sweep_busy_r
      |=> !walk_busy_r && !sweep_busy_r)
    else $error("configuring without master");
  chk_walk_end:
    assert property (s_walk_stop |=> walk_done_r && !walk_busy_r)
    else $error("walk did not stop");
endmodule : ttnr_core_properties
bind ttnr_core ttnr_core_properties #(.TOK_CYCLES(TOK_CYCLES))
  i_ttnr_core_properties (.clk, .sys_rst, .port_reset_done, .token_fwd,
  .token_gen_r, .node_ident_r, .own_prio, .msg_sent, .msg_sent_idx, .pend_r,
  .tx_req, .oper_flag, .tx_grant_r, .tx_refuse_r, .port_now_oper,
  .walk_step, .walk_busy_r, .walk_done_r, .sweep_start, .sweep_busy_r);
`default_nettype wire

// ### tb/ttnr_far_node.sv
// Far-node model: hands the circulating token back on enabled ports.
// Assumes the block's clock and reset.
`default_nettype none
module ttnr_far_node import ttnr_pkg::*; #(
  parameter int GAP = 10
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [NPORT-1:0] en, // Ports with live token
  output logic [NPORT-1:0] token_fwd = '0 // Token passed on
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge clk)
  begin
    cnt <= (sys_rst || cnt == GAP - 1) ? 0 : cnt + 1;
    token_fwd <= (cnt == GAP - 1) ? en : '0;
  end
endmodule : ttnr_far_node
`default_nettype wire

// ### tb/tb_ttnr_core.sv
// Self-checking bench for ttnr_core.
// Assumes the package, core, far-node model and checker are compiled.
`default_nettype none
module tb_ttnr_core import ttnr_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 20;
  localparam logic [23:0] OUI = 24'h5a5a01; // Arbitrary value
  localparam logic [23:0] PROD = 24'h000042; // Arbitrary value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [NPORT-1:0] prd = '0, oper = '0, fen = 2'h1, fwd, tg;
  logic [PRIO_W-1:0] prio = 3'h1;
  ttnr_cfg_wr_t cw = '0;
  ttnr_tx_req_t tx = '0;
  ttnr_walk_step_t ws = '0;
  logic ms = 1'b0, mr = 1'b0, pno = 1'b0, ss = 1'b0, g;
  logic [IDXW-1:0] mi = '0;
  logic [63:0] nid;
  logic [NREC-1:0] pend;
  logic gr, rf, wb, wd, sb;
  ttnr_setup_req_t sq;
  logic [1:0] qtx[$];
  ttnr_alert_wr_t sa = '0;
  ttnr_alert_rec_t arec;
  ttnr_cfg_rec_t crd;
  ttnr_cfg_rec_t recs[NREC];
  logic ar = 1'b0, ah;
  logic [15:0] at = '0;
  logic [IDXW-1:0] ri = '0;
  logic [IDXW+PW-1:0] qsq[$];
  ttnr_alert_rec_t qal[$];
  int nah = 0;
  int err_total = 0, check_count = 0, ncyc = 0, nsq = 0, tl = 0;
  initial
    forever #5 clk = ~clk;
  ttnr_far_node #(.GAP(10)) i_ttnr_far_node (.clk(clk), .sys_rst(sys_rst),
    .en(fen), .token_fwd(fwd));
  ttnr_core #(.TOK_CYCLES(TC), .OUI(OUI), .PRODUCT(PROD)) i_ttnr_core (
    .clk(clk), .sys_rst(sys_rst), .port_reset_done(prd), .token_fwd(fwd),
    .oper_flag(oper), .own_prio(prio), .cfg_wr(cw), .cfg_rd_idx(ri),
    .setup_sent(sa), .alert_rx(ar), .alert_rx_tag(at),
    .msg_sent(ms), .msg_sent_idx(mi), .msg_reply(mr), .msg_reply_idx(mi),
    .tx_req(tx), .port_now_oper(pno), .walk_step(ws), .sweep_start(ss),
    .token_gen_r(tg), .node_ident_r(nid), .cfg_rd_r(crd), .pend_r(pend),
    .alert_hit_r(ah), .alert_rec_r(arec), .tx_grant_r(gr), .tx_refuse_r(rf),
    .walk_busy_r(wb), .walk_done_r(wd), .setup_req_r(sq), .sweep_busy_r(sb));
  task automatic chk(string n, logic [127:0] e, logic [127:0] v);
    check_count++;
    if (v !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask : chk
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask : step
  // Result watcher, also the hang guard
  always @(negedge clk)
  begin
    ncyc++;
    if (sq.valid)
    begin
      nsq++;
      chk("setup req", qsq.pop_front(), {sq.idx, sq.port});
    end
    if (ah)
    begin
      nah++;
      chk("alert rec", qal.pop_front(), arec);
    end
    if (gr | rf)
      chk("tx gate", qtx.pop_front(), {gr, rf});
    if (tg[0] && fen[0])
      chk("token kept", 1'b0, tg[0]);
    if (tg[1] && tl > 0)
      chk("token gap", TC, ncyc - tl);
    if (tg[1])
      tl = ncyc;
    if (ncyc > 3000)
    begin
      err_total++;
      end_of_test();
    end
  end
  initial
  begin
    void'($urandom(32'h4fc38205));
    step(5);
    sys_rst = 1'b0;
    step(3 * TC);
    chk("ident", {ID_RSVD, OUI, PROD}, nid);
    fen = '0;
    step(2 * TC);
    prd = 2'h1;
    step(1);
    prd = '0;
    step(2 * TC);
    $display("test token end");
    for (int i = 0; i < 24; i++)
    begin
      oper = NPORT'($urandom);
      tx = '{1'b1, PW'($urandom), 1'($urandom)};
      g = oper[tx.port] | tx.reset_ctrl;
      qtx.push_back({g, ~g});
      step(1);
    end
    tx = '0;
    $display("test gate end");
    for (int p = 0; p < 2; p++)
    begin
      prio = p ? PRIO_NONE : PRIO_W'($urandom_range(7, 1));
      mi = IDXW'($urandom);
      ms = 1'b1;
      step(1);
      ms = 1'b0;
      step(1);
      chk("pend set", !p, pend[mi]);
      mr = 1'b1;
      step(1);
      mr = 1'b0;
      step(1);
      chk("pend clear", 1'b0, pend[mi]);
    end
    pno = 1'b1;
    ss = 1'b1;
    step(1);
    pno = 1'b0;
    ss = 1'b0;
    step(1);
    chk("no master", 2'h0, {wb, sb});
    prio = 3'h5;
    ms = 1'b1;
    mr = 1'b1;
    step(1);
    ms = 1'b0;
    mr = 1'b0;
    step(1);
    chk("pend race", 1'b1, pend[mi]);
    $display("test pend end");
    for (int k = 0; k < 3; k++)
    begin
      pno = 1'b1;
      step(1);
      pno = 1'b0;
      ws = '{1'b1, 2'h2, 1'b1, 1'b0};
      step(1);
      chk("walk busy", 1'b1, wb);
      ws = '{1'b1, k == 0 ? NPORTS_SINGLE : 2'h2, k != 1, k == 2};
      step(1);
      chk("walk done", 1'b1, wd);
      ws = '0;
      step(1);
      chk("walk end", 1'b0, wb);
    end
    $display("test walk end");
    for (int r = 0; r < NREC; r++)
    begin
      cw = '{1'b1, IDXW'(r), '{1'b1, {$urandom, $urandom},
        PRIO_W'($urandom), 2'h2, $urandom, PW'($urandom)}};
      recs[r] = cw.rec;
      step(1);
    end
    cw = '0;
    oper = NPORT'($urandom);
    nsq = 0;
    for (int r = 0; r < NREC * NPORT; r++)
      qsq.push_back((IDXW + PW)'(r));
    ss = 1'b1;
    step(1);
    ss = 1'b0;
    for (int w = 0; w < 80 && sb; w++)
      step(1);
    step(4);
    chk("sweep reqs", NREC * NPORT, nsq);
    $display("test sweep end");
    for (int r = 0; r < NREC; r++)
    begin
      ri = IDXW'(r);
      step(2);
      chk("cfg read", recs[r], crd);
    end
    prio = PRIO_NONE;
    cw = '{1'b1, '0, '0};
    step(1);
    cw = '0;
    ri = '0;
    step(2);
    chk("cfg kept", recs[0], crd);
    $display("test cfg end");
    prio = 3'h5;
    for (int a = 0; a < 4; a++)
    begin
      sa.valid = 1'b1;
      sa.rec = '{16'({$urandom, IDXW'(a)}), $urandom, 8'($urandom),
        IDXW'($urandom)};
      step(1);
      sa.valid = 1'b0;
      ar = 1'b1;
      at = sa.rec.alert_tag;
      qal.push_back(sa.rec);
      step(1);
      at = at ^ 16'h8000;
      step(1);
      ar = 1'b0;
    end
    step(3);
    chk("alert hits", 4, nah);
    $display("test alert end");
    end_of_test();
  end
endmodule : tb_ttnr_core
`default_nettype wire
